/* File: bench/tb_aif_regs.sv */
// Self-checking bench for the audio frame status register group
`timescale 1ns/1ps
`default_nettype none
module tb_aif_regs;
    import aif_pkg::*;

    logic              mclk_i;
    logic              rst_i;
    logic [ADDR_W-1:0] addr_i;
    logic [DATA_W-1:0] wdata_i;
    logic              wr_i;
    logic              rd_i;
    logic [DATA_W-1:0] rdata_o;
    logic              aud_v;
    logic              pd_v;
    logic [7:0]        ver;
    logic [3:0]        ct;
    logic [2:0]        cc;
    logic [2:0]        sf;
    logic [1:0]        ss;
    logic [7:0]        br;
    logic [7:0]        sp;
    logic              dm;
    logic [3:0]        lv;
    logic [7:0]        pd_ver;
    logic [6:0]        vn;
    logic [FLAG_W-1:0] other;
    logic              ext_rd;
    logic [FLAG_W-1:0] flags;
    logic              irq_o;
    int                failures;
    int                total_checks;

    localparam int EV_AUD = 0;
    localparam int EV_PD  = 1;
    localparam int EV_EXT = 2;

    aif_regs dut (
        .mclk_i                   (mclk_i),
        .rst_i                    (rst_i),
        .addr_i                   (addr_i),
        .wdata_i                  (wdata_i),
        .wr_i                     (wr_i),
        .rd_i                     (rd_i),
        .rdata_o                  (rdata_o),
        .audio_valid_i            (aud_v),
        .audio_version_i          (ver),
        .audio_coding_type_i      (ct),
        .channel_count_code_i     (cc),
        .sample_rate_code_i       (sf),
        .sample_size_code_i       (ss),
        .peak_bitrate_i           (br),
        .speaker_placement_i      (sp),
        .downmix_block_i          (dm),
        .level_shift_value_i      (lv),
        .prod_desc_valid_i        (pd_v),
        .prod_desc_version_i      (pd_ver),
        .vendor_name_char_first_i (vn),
        .other_change_i           (other),
        .flag_read_ext_i          (ext_rd),
        .new_data_flag_o          (flags),
        .irq_o                    (irq_o)
    );

    initial begin
        mclk_i = 1'b0;
        forever #50 mclk_i = ~mclk_i;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        if (failures == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        wr_i    <= 1'b1;
        addr_i  <= a;
        wdata_i <= d;
        @(posedge mclk_i);
        wr_i    <= 1'b0;
    endtask

    // Data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge mclk_i);
        rd_i   <= 1'b1;
        addr_i <= a;
        @(posedge mclk_i);
        rd_i   <= 1'b0;
        #1;
        check(rdata_o, exp);
    endtask

    // One-cycle event pulse: audio frame, description frame or external flag read
    task automatic pulse(input int sel);
        @(posedge mclk_i);
        aud_v  <= (sel == EV_AUD);
        pd_v   <= (sel == EV_PD);
        ext_rd <= (sel == EV_EXT);
        @(posedge mclk_i);
        {aud_v, pd_v, ext_rd} <= 3'b000;
        #1;
    endtask

    // Frame valid, then a read of byte a in the very next cycle
    task automatic frame_rd(input int sel, input logic [7:0] a, input logic [7:0] exp);
        @(posedge mclk_i);
        aud_v <= (sel == EV_AUD);
        pd_v  <= (sel == EV_PD);
        @(posedge mclk_i);
        {aud_v, pd_v} <= 2'b00;
        rd_i   <= 1'b1;
        addr_i <= a;
        @(posedge mclk_i);
        rd_i   <= 1'b0;
        #1;
        check(rdata_o, exp);
    endtask

    task automatic chk_aud();
        rd(OFF_AUD_VERSION, ver);
        rd(OFF_AUD_CODING, {ct, 1'b0, cc});
        rd(OFF_AUD_RATE, {3'b000, sf, ss});
        rd(OFF_AUD_BITRATE, br);
        rd(OFF_AUD_SPEAKER, sp);
        rd(OFF_AUD_DOWNMIX, {dm, lv, 3'b000});
    endtask

    initial begin
        repeat (5000) @(posedge mclk_i);
        failures++;
        end_sim();
    end

    initial begin
        failures = 0;
        total_checks = 0;
        {addr_i, wdata_i, wr_i, rd_i, aud_v, pd_v, ext_rd} = '0;
        {ver, ct, cc, sf, ss, br, sp, dm, lv, pd_ver, vn, other} = '0;
        rst_i = 1'b1;
        repeat (4) @(posedge mclk_i);
        rst_i <= 1'b0;
        chk_aud();
        rd(OFF_FLAG_MIRROR, 8'h00);
        wr(OFF_IRQ_MASK, 8'h01);
        rd(OFF_IRQ_MASK, 8'h01);
        // First frame: flag bit 1 and interrupt
        @(posedge mclk_i);
        {ver, ct, cc, sf, ss, br, sp, dm, lv} <= {8'h01, 4'h2, 3'h1, 3'h3, 2'h1,
                                                   8'h60, 8'h00, 1'b0, 4'h5};
        pulse(EV_AUD);
        check({1'b0, flags}, 8'h02);
        check({7'h00, irq_o}, 8'h01);
        chk_aud();
        rd(OFF_FLAG_MIRROR, 8'h02);
        check({1'b0, flags}, 8'h00);
        rd(OFF_IRQ_STATUS, 8'h01);
        check({7'h00, irq_o}, 8'h00);
        // Unchanged content raises nothing
        pulse(EV_AUD);
        check({1'b0, flags}, 8'h00);
        // Boundary codes; a write to a read-only byte is dropped
        wr(OFF_AUD_CODING, 8'h55);
        rd(OFF_AUD_CODING, 8'h21);
        @(posedge mclk_i);
        {ver, ct, cc, sf, ss, br, sp, dm, lv} <= {8'h02, 4'h8, 3'h7, 3'h7, 2'h3,
                                                   8'hFF, 8'h31, 1'b1, 4'hF};
        frame_rd(EV_AUD, OFF_AUD_CODING, 8'h87);
        frame_rd(EV_AUD, OFF_AUD_RATE, 8'h1F);
        frame_rd(EV_AUD, OFF_AUD_BITRATE, 8'hFF);
        frame_rd(EV_AUD, OFF_AUD_SPEAKER, 8'h31);
        frame_rd(EV_AUD, OFF_AUD_DOWNMIX, 8'hF8);
        frame_rd(EV_AUD, OFF_AUD_VERSION, 8'h02);
        chk_aud();
        // Masked: status set but no interrupt
        wr(OFF_IRQ_MASK, 8'h00);
        rd(OFF_IRQ_STATUS, 8'h01);
        @(posedge mclk_i);
        lv <= 4'h0;
        pulse(EV_AUD);
        check({7'h00, irq_o}, 8'h00);
        rd(OFF_AUD_DOWNMIX, 8'h80);
        pulse(EV_EXT);
        check({1'b0, flags}, 8'h00);
        // Product description frame
        @(posedge mclk_i);
        {pd_ver, vn} <= {8'h5A, 7'h7F};
        pulse(EV_PD);
        check({1'b0, flags}, 8'h04);
        frame_rd(EV_PD, OFF_PD_VERSION, 8'h5A);
        frame_rd(EV_PD, OFF_VENDOR_1ST, 8'h7F);
        @(posedge mclk_i);
        other <= 7'h41;
        @(posedge mclk_i);
        other <= 7'h00;
        rd(OFF_FLAG_MIRROR, 8'h45);
        rd(OFF_FLAG_MIRROR, 8'h00);
        rd(OFF_AUD_RSVD, RD_ZERO);
        rd(8'hC0, RD_ZERO);
        // Both status bits unmasked, then a reset in mid-run
        wr(OFF_IRQ_MASK, 8'h03);
        rd(OFF_IRQ_MASK, 8'h03);
        check({7'h00, irq_o}, 8'h01);
        @(posedge mclk_i);
        rst_i <= 1'b1;
        @(posedge mclk_i);
        rst_i <= 1'b0;
        #1;
        check({1'b0, flags}, 8'h00);
        check({7'h00, irq_o}, 8'h00);
        rd(OFF_IRQ_MASK, 8'h00);
        rd(OFF_AUD_DOWNMIX, 8'h00);
        end_sim();
    end
endmodule
`default_nettype wire

/* File: common/aif_pkg.sv */
// Offsets, field positions and reset values of the audio frame register group
package aif_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int FLAG_W = 7;
    localparam int STAT_W = 2;

    localparam logic [7:0] OFF_AUD_VERSION = 8'h90;
    localparam logic [7:0] OFF_AUD_CODING  = 8'h91;
    localparam logic [7:0] OFF_AUD_RATE    = 8'h92;
    localparam logic [7:0] OFF_AUD_BITRATE = 8'h93;
    localparam logic [7:0] OFF_AUD_SPEAKER = 8'h94;
    localparam logic [7:0] OFF_AUD_DOWNMIX = 8'h95;
    localparam logic [7:0] OFF_AUD_RSVD    = 8'h96;
    localparam logic [7:0] OFF_FLAG_MIRROR = 8'h97;
    localparam logic [7:0] OFF_PD_VERSION  = 8'h98;
    localparam logic [7:0] OFF_VENDOR_1ST  = 8'h99;
    localparam logic [7:0] OFF_IRQ_STATUS  = 8'hB8;
    localparam logic [7:0] OFF_IRQ_MASK    = 8'hB9;

    // Field positions (lsb) inside their bytes
    localparam int POS_CODING   = 4;
    localparam int POS_CHANNELS = 0;
    localparam int POS_RATE     = 2;
    localparam int POS_SIZE     = 0;
    localparam int POS_DOWNMIX  = 7;
    localparam int POS_LEVEL    = 3;

    // Flag bits for a changed audio frame and a changed description frame; the rest come from other packets
    localparam int FLAG_AUDIO   = 1;
    localparam int FLAG_PROD    = 2;

    // Interrupt status bits
    localparam int STAT_AUDIO   = 0;
    localparam int STAT_PROD    = 1;

    localparam logic [7:0] RST_BYTE  = 8'h00;
    localparam logic [6:0] RST_FLAGS = 7'h00;
    localparam logic [1:0] RST_STAT  = 2'h0;
    localparam logic [1:0] RST_MASK  = 2'h0;
    localparam logic [7:0] RD_ZERO   = 8'h00;
endpackage

/* File: rtl/aif_regs.sv */
// Audio information frame status registers with change flags and interrupt
//
// Contract
// - Coding type reported in bits 7 to 4
// - Channel count code in three low bits
// - Sample rate code in bits 4 to 2
// - Sample size code in bits 1 to 0
// - Eight-bit peak bit rate field exposed
// - Eight-bit speaker placement code exposed
// - Down-mix block flag in bit 7
// - Level shift value in bits 6 to 3
// - Flag mirror at 0x97 equals primary flags
// - First vendor character as 7-bit code
// - Any flag register read clears all flags (a flag set in the same cycle stays set)
// - Audio frame content change sets flag 1
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module aif_regs
    import aif_pkg::*;
(
    input  wire logic              mclk_i,
    input  wire logic              rst_i,
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [DATA_W-1:0] wdata_i,
    input  wire logic              wr_i,
    input  wire logic              rd_i,
    output logic      [DATA_W-1:0] rdata_o,
    input  wire logic              audio_valid_i,
    input  wire logic [7:0]        audio_version_i,
    input  wire logic [3:0]        audio_coding_type_i,
    input  wire logic [2:0]        channel_count_code_i,
    input  wire logic [2:0]        sample_rate_code_i,
    input  wire logic [1:0]        sample_size_code_i,
    input  wire logic [7:0]        peak_bitrate_i,
    input  wire logic [7:0]        speaker_placement_i,
    input  wire logic              downmix_block_i,
    input  wire logic [3:0]        level_shift_value_i,
    input  wire logic              prod_desc_valid_i,
    input  wire logic [7:0]        prod_desc_version_i,
    input  wire logic [6:0]        vendor_name_char_first_i,
    input  wire logic [FLAG_W-1:0] other_change_i,
    input  wire logic              flag_read_ext_i,
    output logic      [FLAG_W-1:0] new_data_flag_o,
    output logic                   irq_o
);

    logic [7:0]        aud_version_ff;
    logic [3:0]        coding_ff;
    logic [2:0]        channels_ff;
    logic [2:0]        rate_ff;
    logic [1:0]        size_ff;
    logic [7:0]        bitrate_ff;
    logic [7:0]        speaker_ff;
    logic              downmix_ff;
    logic [3:0]        level_ff;
    logic              aud_seen_ff;
    logic [7:0]        pd_version_ff;
    logic [6:0]        vendor_ff;
    logic              pd_seen_ff;
    logic [FLAG_W-1:0] flags_ff;
    logic [STAT_W-1:0] status_ff;
    logic [STAT_W-1:0] mask_ff;
    logic [DATA_W-1:0] rdata_ff;

    logic [40:0]       aud_new;
    logic [40:0]       aud_old;
    logic              aud_change;
    logic              pd_change;
    logic [FLAG_W-1:0] flag_set;
    logic              flag_clear;
    logic [STAT_W-1:0] stat_set;
    logic              stat_clear;
    logic [DATA_W-1:0] nxt_rdata;

    // Whole frame content, so a change in any field counts
    assign aud_new = {audio_version_i, audio_coding_type_i,
                      channel_count_code_i, sample_rate_code_i,
                      sample_size_code_i, peak_bitrate_i,
                      speaker_placement_i, downmix_block_i,
                      level_shift_value_i};
    assign aud_old = {aud_version_ff, coding_ff, channels_ff, rate_ff,
                      size_ff, bitrate_ff, speaker_ff, downmix_ff,
                      level_ff};

    // First frame after reset always counts as new content
    assign aud_change = audio_valid_i && (!aud_seen_ff || aud_new != aud_old);
    assign pd_change  = prod_desc_valid_i &&
                        (!pd_seen_ff ||
                         {prod_desc_version_i, vendor_name_char_first_i} !=
                         {pd_version_ff, vendor_ff});

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            aud_version_ff <= RST_BYTE;
            coding_ff      <= 4'h0;
            channels_ff    <= 3'h0;
            rate_ff        <= 3'h0;
            size_ff        <= 2'h0;
            bitrate_ff     <= RST_BYTE;
            speaker_ff     <= RST_BYTE;
            downmix_ff     <= 1'b0;
            level_ff       <= 4'h0;
            aud_seen_ff    <= 1'b0;
        end else if (audio_valid_i) begin
            aud_version_ff <= audio_version_i;
            coding_ff      <= audio_coding_type_i;
            channels_ff    <= channel_count_code_i;
            rate_ff        <= sample_rate_code_i;
            size_ff        <= sample_size_code_i;
            bitrate_ff     <= peak_bitrate_i;
            speaker_ff     <= speaker_placement_i;
            downmix_ff     <= downmix_block_i;
            level_ff       <= level_shift_value_i;
            aud_seen_ff    <= 1'b1;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            pd_version_ff <= RST_BYTE;
            vendor_ff     <= 7'h00;
            pd_seen_ff    <= 1'b0;
        end else if (prod_desc_valid_i) begin
            pd_version_ff <= prod_desc_version_i;
            vendor_ff     <= vendor_name_char_first_i;
            pd_seen_ff    <= 1'b1;
        end
    end

    always_comb begin
        flag_set             = other_change_i;
        flag_set[FLAG_AUDIO] = other_change_i[FLAG_AUDIO] | aud_change;
        flag_set[FLAG_PROD]  = other_change_i[FLAG_PROD] | pd_change;
    end

    // Reads of the sibling flag copies elsewhere arrive as flag_read_ext_i
    assign flag_clear = flag_read_ext_i || (rd_i && addr_i == OFF_FLAG_MIRROR);

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            flags_ff <= RST_FLAGS;
        end else begin
            flags_ff <= (flag_clear ? RST_FLAGS : flags_ff) | flag_set;
        end
    end

    assign stat_set   = {pd_change, aud_change};
    assign stat_clear = rd_i && addr_i == OFF_IRQ_STATUS;

    // Sticky events; a new event in the clearing cycle survives
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            status_ff <= RST_STAT;
        end else begin
            status_ff <= (stat_clear ? RST_STAT : status_ff) | stat_set;
        end
    end

    // Only the mask is writable; writes elsewhere are dropped
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            mask_ff <= RST_MASK;
        end else if (wr_i && addr_i == OFF_IRQ_MASK) begin
            mask_ff <= wdata_i[STAT_W-1:0];
        end
    end

    // Read multiplexer; reserved and unmapped bytes read as zero
    always_comb begin
        nxt_rdata = RD_ZERO;
        unique case (addr_i)
            OFF_AUD_VERSION: nxt_rdata = aud_version_ff;
            OFF_AUD_CODING: begin
                nxt_rdata[POS_CODING +: 4]   = coding_ff;
                nxt_rdata[POS_CHANNELS +: 3] = channels_ff;
            end
            OFF_AUD_RATE: begin
                nxt_rdata[POS_RATE +: 3] = rate_ff;
                nxt_rdata[POS_SIZE +: 2] = size_ff;
            end
            OFF_AUD_BITRATE: nxt_rdata = bitrate_ff;
            OFF_AUD_SPEAKER: nxt_rdata = speaker_ff;
            OFF_AUD_DOWNMIX: begin
                nxt_rdata[POS_DOWNMIX]    = downmix_ff;
                nxt_rdata[POS_LEVEL +: 4] = level_ff;
            end
            OFF_AUD_RSVD: nxt_rdata = RD_ZERO;
            OFF_FLAG_MIRROR: nxt_rdata = {1'b0, flags_ff};
            OFF_PD_VERSION:  nxt_rdata = pd_version_ff;
            OFF_VENDOR_1ST:  nxt_rdata = {1'b0, vendor_ff};
            OFF_IRQ_STATUS:  nxt_rdata = {6'h00, status_ff};
            OFF_IRQ_MASK:    nxt_rdata = {6'h00, mask_ff};
            default:         nxt_rdata = RD_ZERO;
        endcase
    end

    // Data stands only in the cycle after the strobe
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            rdata_ff <= RD_ZERO;
        end else begin
            rdata_ff <= rd_i ? nxt_rdata : RD_ZERO;
        end
    end

    assign rdata_o         = rdata_ff;
    assign new_data_flag_o = flags_ff;
    assign irq_o           = |(status_ff & mask_ff);

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    sequence s_rd(logic [7:0] a);
        rd_i && addr_i == a;
    endsequence

    sequence s_frame_then_rd(logic [7:0] a);
        audio_valid_i ##1 (rd_i && addr_i == a && !audio_valid_i);
    endsequence

    sequence s_desc_then_rd(logic [7:0] a);
        prod_desc_valid_i ##1 (rd_i && addr_i == a && !prod_desc_valid_i);
    endsequence

    coding_read_a: assert property (
        s_frame_then_rd(OFF_AUD_CODING) |=>
            rdata_o[7:4] == $past(audio_coding_type_i, 2) && !rdata_o[3])
        else $error("coding type field wrong");

    channel_read_a: assert property (
        s_frame_then_rd(OFF_AUD_CODING) |=>
            rdata_o[2:0] == $past(channel_count_code_i, 2))
        else $error("channel count field wrong");

    rate_read_a: assert property (
        s_rd(OFF_AUD_RATE) |=>
            rdata_o[4:2] == $past(rate_ff) && rdata_o[7:5] == 3'h0)
        else $error("sample rate field wrong");

    size_read_a: assert property (
        s_frame_then_rd(OFF_AUD_RATE) |=>
            rdata_o[1:0] == $past(sample_size_code_i, 2))
        else $error("sample size field wrong");

    bitrate_read_a: assert property (
        s_frame_then_rd(OFF_AUD_BITRATE) |=>
            rdata_o == $past(peak_bitrate_i, 2))
        else $error("peak bit rate wrong");

    speaker_read_a: assert property (
        s_frame_then_rd(OFF_AUD_SPEAKER) |=>
            rdata_o == $past(speaker_placement_i, 2))
        else $error("speaker placement wrong");

    downmix_read_a: assert property (
        s_frame_then_rd(OFF_AUD_DOWNMIX) |=>
            rdata_o[7] == $past(downmix_block_i, 2))
        else $error("down-mix flag wrong");

    level_read_a: assert property (
        s_frame_then_rd(OFF_AUD_DOWNMIX) |=>
            rdata_o[6:3] == $past(level_shift_value_i, 2)
            && rdata_o[2:0] == 3'h0)
        else $error("level shift field wrong");

    flag_mirror_a: assert property (
        s_rd(OFF_FLAG_MIRROR) |=>
            rdata_o == {1'b0, $past(new_data_flag_o)})
        else $error("flag mirror differs");

    vendor_read_a: assert property (
        s_desc_then_rd(OFF_VENDOR_1ST) |=>
            rdata_o == {1'b0, $past(vendor_name_char_first_i, 2)})
        else $error("vendor character wrong");

    flag_clear_a: assert property (
        flag_clear && other_change_i == 7'h00 && !aud_change && !pd_change
            |=> new_data_flag_o == 7'h00)
        else $error("flags not cleared by read");

    audio_flag_a: assert property (
        audio_valid_i && aud_seen_ff && aud_new != aud_old
            |=> new_data_flag_o[FLAG_AUDIO] [*1] ##1 1'b1)
        else $error("audio change flag missing");

    frame_hold_a: assert property (
        !audio_valid_i |=> $stable(aud_old))
        else $error("audio fields moved without frame");

    irq_level_a: assert property (
        audio_valid_i && !aud_seen_ff && mask_ff[STAT_AUDIO]
            && !(wr_i && addr_i == OFF_IRQ_MASK) |=> irq_o)
        else $error("interrupt missing");

    // Read-back of the remaining bytes and of the idle bus
    version_read_a: assert property (
        s_frame_then_rd(OFF_AUD_VERSION) |=>
            rdata_o == $past(audio_version_i, 2))
        else $error("audio version wrong");

    pd_version_read_a: assert property (
        s_desc_then_rd(OFF_PD_VERSION) |=>
            rdata_o == $past(prod_desc_version_i, 2))
        else $error("description version wrong");

    rdata_idle_a: assert property (
        !rd_i |=> rdata_o == RD_ZERO)
        else $error("read data outside read slot");

    rsvd_read_a: assert property (
        s_rd(OFF_AUD_RSVD) |=> rdata_o == RD_ZERO)
        else $error("reserved byte not zero");

    mask_read_a: assert property (
        s_rd(OFF_IRQ_MASK) |=> rdata_o == {6'h00, $past(mask_ff)})
        else $error("mask read wrong");

    status_read_a: assert property (
        s_rd(OFF_IRQ_STATUS) |=> rdata_o == {6'h00, $past(status_ff)})
        else $error("status read wrong");

    // Flag and status bookkeeping; a set beats a clear
    other_flag_a: assert property (
        other_change_i[0] |=> new_data_flag_o[0])
        else $error("other packet flag missing");

    pd_flag_a: assert property (
        pd_change |=> new_data_flag_o[FLAG_PROD])
        else $error("description flag missing");

    flag_hold_a: assert property (
        !flag_clear && other_change_i == 7'h00 && !aud_change && !pd_change
            |=> $stable(new_data_flag_o))
        else $error("flags moved without cause");

    status_set_a: assert property (
        aud_change |=> status_ff[STAT_AUDIO])
        else $error("audio status not set");

    status_clear_a: assert property (
        stat_clear && !aud_change && !pd_change
            |=> status_ff == RST_STAT && !irq_o)
        else $error("status not cleared by read");

    mask_write_a: assert property (
        wr_i && addr_i == OFF_IRQ_MASK
            |=> mask_ff == $past(wdata_i[STAT_W-1:0]))
        else $error("mask write lost");

    irq_prod_a: assert property (
        status_ff[STAT_PROD] && mask_ff[STAT_PROD] |-> irq_o)
        else $error("description interrupt missing");

    pd_hold_a: assert property (
        !prod_desc_valid_i |=> $stable(vendor_ff) && $stable(pd_version_ff))
        else $error("description fields moved");

endmodule
`default_nettype wire
